//--- nvx_cmd.sv
// Purpose: command sequencer of the nvm controller when driven from the program/debug port
// Assumes: one 200 MHz clock; array back end answers each start with one done pulse
// Notes:   page buffers live here; the back end reads them through the buffer read port
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
module nvx_cmd
  import nvx_pkg::*;
#(
  parameter int AW         = 24,
  parameter int FBUF_WORDS = 64,
  parameter int EBUF_BYTES = 32,
  parameter logic [23:0] FLASH_BASE  = 24'h800000,
  parameter logic [23:0] FLASH_BYTES = 24'h000100,
  parameter logic [23:0] BOOT_BASE   = 24'h8000C0,
  parameter logic [23:0] BOOT_BYTES  = 24'h000040,
  parameter int FUSE_COUNT = 8
) (
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic [7:0]    reg_addr_i,
  input  wire logic [31:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [31:0]   reg_rdata_o,
  input  wire logic [AW-1:0] dp_addr_i,
  input  wire logic [7:0]    dp_wdata_i,
  input  wire logic          dp_wr_i,
  input  wire logic          dp_rd_i,
  output logic      [7:0]    dp_rdata_o,
  output logic               dp_rvalid_o,
  output logic               dp_stall_o,
  output logic               mem_start_o,
  output logic      [6:0]    mem_cmd_o,
  output logic      [AW-1:0] mem_addr_o,
  output logic               mem_keep_eeprom_o,
  input  wire logic          mem_done_i,
  output logic               mem_rd_o,
  output logic      [AW-1:0] mem_rd_addr_o,
  input  wire logic [7:0]    mem_rd_data_i,
  input  wire logic [5:0]    buf_rd_idx_i,
  output logic      [16:0]   buf_rd_data_o,
  output logic               busy_o,
  output logic               memory_interface_enabled_o
);

  typedef enum logic [2:0] {NVX_IDLE, NVX_BACKEND, NVX_LOCAL, NVX_CRC_RD, NVX_CRC_WAIT, NVX_CRC_ACC} nvx_state_t;

  nvx_state_t         state_r;
  logic [6:0]         cmd_r;
  logic [15:0]        data_r;
  logic [7:0]         lock_r;
  logic [7:0]         fuse_r [FUSE_COUNT];
  logic [15:0]        fbuf_r [FBUF_WORDS];
  logic [7:0]         ebuf_r [EBUF_BYTES];
  logic [EBUF_BYTES-1:0] etag_r;
  logic [7:0]         tmp_lo_r;
  logic               ifen_r;
  logic [1:0]         rd_stage_r;
  logic [3:0]         load_stall_r;
  logic [15:0]        crc_r;
  logic [AW-1:0]      crc_addr_r;
  logic [AW-1:0]      crc_last_r;
  logic               clr_fbuf_r;
  logic               clr_ebuf_r;
  logic               busy;
  logic               locked_all;
  logic               allowed;
  logic               exec_go;
  logic               dp_idle;
  logic               wr_go;
  logic               rd_go;

  // bitwise crc update over one byte
  function automatic logic [15:0] nvx_crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      v = v[15] ? ((v << 1) ^ NVX_CRC_POLY) : (v << 1);
    end
    return v;
  endfunction

  // trigger qualification
  assign busy       = (state_r != NVX_IDLE);
  assign locked_all = (lock_r[1:0] == 2'b00);
  assign allowed    = !locked_all || cmd_r == NVX_C_CHIP_ERASE || cmd_r == NVX_C_FLASH_CRC;
  assign exec_go = reg_wr_i && reg_addr_i == NVX_REG_CONTROL_REGISTER_A && reg_wdata_i[NVX_CONTROL_REGISTER_A_EXEC_BIT]
                   && !busy && allowed && nvx_is_action(cmd_r);
  // debug-port triggers ignored while busy or stalled
  assign dp_idle = !busy && ifen_r && rd_stage_r == 2'd0 && load_stall_r == 4'd0;
  assign wr_go   = dp_wr_i && dp_idle && allowed && nvx_is_write(cmd_r);
  assign rd_go   = dp_rd_i && dp_idle;

  assign busy_o                     = busy;
  assign memory_interface_enabled_o = ifen_r;
  // stall covers busy, read in flight, post-load hold and a disconnected bus
  assign dp_stall_o = !dp_idle;

  // sequencer: busy from launch to completion
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r     <= NVX_IDLE;
      mem_start_o <= 1'b0;
      mem_cmd_o   <= NVX_C_NOP;
      mem_addr_o  <= '0;
      crc_addr_r  <= '0;
      crc_last_r  <= '0;
      crc_r       <= NVX_CRC_INIT;
    end else begin
      mem_start_o <= 1'b0;
      unique case (state_r)
        NVX_IDLE: begin
          if (exec_go) begin
            mem_cmd_o <= cmd_r;
            if (cmd_r == NVX_C_FLASH_CRC || cmd_r == NVX_C_BOOT_CRC) begin
              crc_addr_r <= (cmd_r == NVX_C_BOOT_CRC) ? BOOT_BASE[AW-1:0] : FLASH_BASE[AW-1:0];
              crc_last_r <= (cmd_r == NVX_C_BOOT_CRC) ? AW'(BOOT_BASE + BOOT_BYTES - 24'h000001)
                                                      : AW'(FLASH_BASE + FLASH_BYTES - 24'h000001);
              crc_r      <= NVX_CRC_INIT;
              state_r    <= NVX_CRC_RD;
            end else if (nvx_is_backend(cmd_r)) begin
              // whole section erase on execute bit
              mem_start_o <= 1'b1;
              state_r     <= NVX_BACKEND;
            end else begin
              state_r <= NVX_LOCAL;
            end
          end else if (wr_go) begin
            mem_cmd_o <= cmd_r;
            // page chosen by the written address
            mem_addr_o <= dp_addr_i;
            if (nvx_is_backend(cmd_r)) begin
              // page ops as one back-end run
              mem_start_o <= 1'b1;
              state_r     <= NVX_BACKEND;
            end else if (cmd_r == NVX_C_FUSE_WR || cmd_r == NVX_C_LOCK_WR) begin
              state_r <= NVX_LOCAL;
            end
          end
        end
        NVX_BACKEND: begin
          if (mem_done_i) begin
            state_r <= NVX_IDLE;
          end
        end
        NVX_LOCAL: begin
          state_r <= NVX_IDLE;
        end
        NVX_CRC_RD: begin
          state_r <= NVX_CRC_WAIT;
        end
        NVX_CRC_WAIT: begin
          state_r <= NVX_CRC_ACC;
        end
        NVX_CRC_ACC: begin
          crc_r      <= nvx_crc_byte(crc_r, mem_rd_data_i);
          crc_addr_r <= crc_addr_r + AW'(1);
          state_r    <= (crc_addr_r == crc_last_r) ? NVX_IDLE : NVX_CRC_RD;
        end
      endcase
    end
  end

  // eeprom kept when preserve fuse programmed (bit low)
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mem_keep_eeprom_o <= 1'b0;
    end else if (exec_go) begin
      mem_keep_eeprom_o <= !fuse_r[NVX_EEPROM_PRESERVE_FUSE_FUSE_IDX][NVX_EEPROM_PRESERVE_FUSE_BIT];
    end
  end

  // bus disconnected during chip erase and flash crc
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ifen_r <= 1'b1;
    end else if (exec_go && (cmd_r == NVX_C_CHIP_ERASE || cmd_r == NVX_C_FLASH_CRC)) begin
      ifen_r <= 1'b0;
    end else if (!busy) begin
      ifen_r <= 1'b1;
    end
  end

  // command and data registers; writes while busy are dropped so the running op stays coherent
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_r  <= NVX_CMD_RESET;
      data_r <= '0;
    end else if (state_r == NVX_CRC_ACC && crc_addr_r == crc_last_r) begin
      data_r <= nvx_crc_byte(crc_r, mem_rd_data_i);
    end else if (reg_wr_i && !busy) begin
      if (reg_addr_i == NVX_REG_CMD) begin
        cmd_r <= reg_wdata_i[6:0];
      end
      if (reg_addr_i == NVX_REG_DATA) begin
        data_r <= reg_wdata_i[15:0];
      end
    end
  end

  // fuses and lock bits: and-merge, bits only go from erased toward programmed; chip erase resets the lock bits
  // nothing here touches fuses on chip erase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lock_r <= NVX_LOCK_RESET;
      for (int i = 0; i < FUSE_COUNT; i++) begin
        fuse_r[i] <= NVX_FUSE_RESET;
      end
    end else if (state_r == NVX_BACKEND && mem_done_i && mem_cmd_o == NVX_C_CHIP_ERASE) begin
      lock_r <= NVX_LOCK_RESET;
    end else if (wr_go && cmd_r == NVX_C_FUSE_WR) begin
      fuse_r[dp_addr_i[2:0]] <= fuse_r[dp_addr_i[2:0]] & dp_wdata_i;
    end else if (wr_go && cmd_r == NVX_C_LOCK_WR) begin
      lock_r <= lock_r & dp_wdata_i;
    end else if (exec_go && cmd_r == NVX_C_LOCK_WR) begin
      lock_r <= lock_r & data_r[7:0];
    end
  end

  // buffer clear requests, applied in the local busy cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clr_fbuf_r <= 1'b0;
      clr_ebuf_r <= 1'b0;
    end else begin
      clr_fbuf_r <= exec_go && cmd_r == NVX_C_FBUF_CLR;
      // eeprom buffer clear on execute bit
      clr_ebuf_r <= exec_go && cmd_r == NVX_C_EBUF_CLR;
    end
  end

  // flash buffer: low byte parked, word stored with the high byte
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tmp_lo_r <= 8'h00;
      for (int i = 0; i < FBUF_WORDS; i++) begin
        fbuf_r[i] <= 16'hFFFF;
      end
    end else if (clr_fbuf_r) begin
      for (int i = 0; i < FBUF_WORDS; i++) begin
        fbuf_r[i] <= 16'hFFFF;
      end
    end else if (wr_go && cmd_r == NVX_C_FLOAD) begin
      // relies on low byte arriving first
      if (!dp_addr_i[0]) begin
        tmp_lo_r <= dp_wdata_i;
      end else begin
        fbuf_r[dp_addr_i[$clog2(FBUF_WORDS):1]] <= {dp_wdata_i, tmp_lo_r};
      end
    end
  end

  // eeprom buffer byte load with tag
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      etag_r <= '0;
      for (int i = 0; i < EBUF_BYTES; i++) begin
        ebuf_r[i] <= 8'hFF;
      end
    end else if (clr_ebuf_r) begin
      etag_r <= '0;
      for (int i = 0; i < EBUF_BYTES; i++) begin
        ebuf_r[i] <= 8'hFF;
      end
    end else if (wr_go && cmd_r == NVX_C_ELOAD) begin
      ebuf_r[dp_addr_i[$clog2(EBUF_BYTES)-1:0]] <= dp_wdata_i;
      etag_r[dp_addr_i[$clog2(EBUF_BYTES)-1:0]] <= 1'b1;
    end
  end

  // hold the port after every buffer load
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_stall_r <= 4'd0;
    end else if (wr_go && (cmd_r == NVX_C_FLOAD || cmd_r == NVX_C_ELOAD)) begin
      load_stall_r <= 4'(NVX_LOAD_STALL_CYC);
    end else if (load_stall_r != 4'd0) begin
      load_stall_r <= load_stall_r - 4'd1;
    end
  end

  // back-end view of the buffers: flash word for flash ops, tag and byte for eeprom ops
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_rd_data_o <= '0;
    end else if (mem_cmd_o inside {NVX_C_EE_PERA, NVX_C_EE_PWR, NVX_C_EE_PEW, NVX_C_EE_ERASE,
                                   NVX_C_ELOAD, NVX_C_EBUF_CLR}) begin
      buf_rd_data_o <= {etag_r[buf_rd_idx_i[$clog2(EBUF_BYTES)-1:0]], 8'h00,
                        ebuf_r[buf_rd_idx_i[$clog2(EBUF_BYTES)-1:0]]};
    end else begin
      buf_rd_data_o <= {1'b1, fbuf_r[buf_rd_idx_i[$clog2(FBUF_WORDS)-1:0]]};
    end
  end

  // read path: array reads take two stages, fuse reads and refusals answer next cycle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_stage_r    <= 2'd0;
      mem_rd_o      <= 1'b0;
      mem_rd_addr_o <= '0;
      dp_rdata_o    <= 8'h00;
      dp_rvalid_o   <= 1'b0;
    end else begin
      mem_rd_o    <= 1'b0;
      dp_rvalid_o <= 1'b0;
      if (state_r == NVX_CRC_RD) begin
        mem_rd_o      <= 1'b1;
        mem_rd_addr_o <= crc_addr_r;
      end else if (rd_go) begin
        if (!allowed || !nvx_is_read(cmd_r)) begin
          dp_rdata_o  <= 8'h00;
          dp_rvalid_o <= 1'b1;
        end else if (cmd_r == NVX_C_FUSE_RD) begin
          dp_rdata_o  <= fuse_r[dp_addr_i[2:0]];
          dp_rvalid_o <= 1'b1;
        end else begin
          mem_rd_o      <= 1'b1;
          mem_rd_addr_o <= dp_addr_i;
          rd_stage_r    <= 2'd1;
        end
      end else if (rd_stage_r == 2'd1) begin
        rd_stage_r <= 2'd2;
      end else if (rd_stage_r == 2'd2) begin
        dp_rdata_o  <= mem_rd_data_i;
        dp_rvalid_o <= 1'b1;
        rd_stage_r  <= 2'd0;
      end
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        NVX_REG_CMD:    reg_rdata_o <= {25'h0, cmd_r};
        NVX_REG_CONTROL_REGISTER_A:  reg_rdata_o <= {31'h0, busy};
        NVX_REG_STATUS: reg_rdata_o <= {29'h0, locked_all, ifen_r, busy};
        NVX_REG_DATA:   reg_rdata_o <= {16'h0, data_r};
        NVX_REG_LOCK:   reg_rdata_o <= {24'h0, lock_r};
        default:        reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

endmodule

//--- nvx_cmd_asserts.sv
// Purpose: port-level checks of the nvm command sequencer
// Assumes: one clock, async active-low reset
// Notes:   command register is shadowed from the register port writes
`timescale 1ns/100ps
module nvx_cmd_asserts
  import nvx_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic [23:0] dp_addr_i,
  input wire logic        dp_wr_i,
  input wire logic        dp_rd_i,
  input wire logic        dp_rvalid_o,
  input wire logic        dp_stall_o,
  input wire logic        mem_start_o,
  input wire logic [6:0]  mem_cmd_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic        mem_done_i,
  input wire logic        busy_o,
  input wire logic        memory_interface_enabled_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [6:0] cmd_r;
  logic       be_r;
  // shadow of the command register; writes while busy are dropped
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cmd_r <= NVX_CMD_RESET;
    else if (reg_wr_i && reg_addr_i == NVX_REG_CMD && !busy_o) cmd_r <= reg_wdata_i[6:0];
  end
  // back-end op in flight, from start to done
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) be_r <= 1'b0;
    else if (mem_start_o) be_r <= 1'b1;
    else if (mem_done_i) be_r <= 1'b0;
  end
  busy_hold_a: assert property (be_r |-> busy_o) else $error("busy low during back-end op");
  stall_busy_a: assert property (busy_o |-> dp_stall_o) else $error("port not stalled while busy");
  start_cmd_a: assert property (mem_start_o |-> mem_cmd_o == cmd_r) else $error("wrong back-end command");
  start_cause_a: assert property (mem_start_o |-> $past(dp_wr_i) || $past(reg_wr_i))
    else $error("start without trigger");
  page_addr_a: assert property (mem_start_o && $past(dp_wr_i) |-> mem_addr_o == $past(dp_addr_i))
    else $error("page address not from store");
  load_stall_a: assert property (dp_wr_i && !dp_stall_o && (cmd_r == NVX_C_FLOAD || cmd_r == NVX_C_ELOAD)
    |=> dp_stall_o && !busy_o) else $error("no stall after buffer load");
  read_answer_a: assert property (dp_rd_i && !dp_stall_o |-> ##[1:3] dp_rvalid_o)
    else $error("load not answered");
  read_idle_a: assert property (dp_rd_i && !dp_stall_o |=> !busy_o [*3]) else $error("read raised busy");
  ifen_busy_a: assert property (!memory_interface_enabled_o |-> busy_o || $past(busy_o))
    else $error("interface off while idle");
  erase_ifen_a: assert property (mem_start_o && mem_cmd_o == NVX_C_CHIP_ERASE
    |-> ##[0:1] !memory_interface_enabled_o) else $error("interface kept on in chip erase");
endmodule
bind nvx_cmd nvx_cmd_asserts nvx_cmd_asserts_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .dp_addr_i(dp_addr_i), .dp_wr_i(dp_wr_i), .dp_rd_i(dp_rd_i),
  .dp_rvalid_o(dp_rvalid_o), .dp_stall_o(dp_stall_o), .mem_start_o(mem_start_o), .mem_cmd_o(mem_cmd_o),
  .mem_addr_o(mem_addr_o), .mem_done_i(mem_done_i), .busy_o(busy_o),
  .memory_interface_enabled_o(memory_interface_enabled_o));

//--- nvx_mem_model.sv
// Purpose: array back end beside the command sequencer
// Assumes: one done pulse per start after a settable delay
// Notes:   idle read data toggles so a stale byte never looks valid
`timescale 1ns/100ps
module nvx_mem_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        mem_start_i,
  input  wire logic [7:0]  delay_i,
  output logic             mem_done_o,
  input  wire logic        mem_rd_i,
  input  wire logic [23:0] mem_rd_addr_i,
  output logic      [7:0]  mem_rd_data_o
);
  logic [7:0] cnt_r;
  // one op per start, erase-write included
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt_r <= 8'h00;
    else if (mem_start_i) cnt_r <= delay_i;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  assign mem_done_o = (cnt_r == 8'h01);
  // byte follows the address one cycle later
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) mem_rd_data_o <= 8'h00;
    else if (mem_rd_i) mem_rd_data_o <= mem_rd_addr_i[7:0] ^ 8'h5A;
    else mem_rd_data_o <= ~mem_rd_data_o;
  end
endmodule

//--- nvx_pkg.sv
// Purpose: constants, command codes and decode helpers for the nvm external command sequencer
// Assumes: byte-wide debug-port memory bus, 32-bit register port
// Notes:   register offsets are byte addresses on the register port
package nvx_pkg;

  // register offsets
  localparam logic [7:0] NVX_REG_CMD    = 8'h00;
  localparam logic [7:0] NVX_REG_CONTROL_REGISTER_A  = 8'h04;
  localparam logic [7:0] NVX_REG_STATUS = 8'h08;
  localparam logic [7:0] NVX_REG_DATA   = 8'h0C;
  localparam logic [7:0] NVX_REG_LOCK   = 8'h10;

  // field positions
  localparam int NVX_CONTROL_REGISTER_A_EXEC_BIT  = 0;
  localparam int NVX_STAT_BUSY_BIT   = 0;
  localparam int NVX_STAT_IFEN_BIT   = 1;
  localparam int NVX_STAT_LOCKED_BIT = 2;
  localparam int NVX_EEPROM_PRESERVE_FUSE_FUSE_IDX = 5;
  localparam int NVX_EEPROM_PRESERVE_FUSE_BIT      = 3;

  // reset values
  localparam logic [6:0]  NVX_CMD_RESET  = 7'h00;
  localparam logic [7:0]  NVX_LOCK_RESET = 8'hFF;
  localparam logic [7:0]  NVX_FUSE_RESET = 8'hFF;
  localparam logic [15:0] NVX_CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] NVX_CRC_POLY   = 16'h1021;

  // timing counts
  localparam int NVX_LOAD_STALL_CYC = 1;

  // command codes
  localparam logic [6:0] NVX_C_NOP       = 7'h00;
  localparam logic [6:0] NVX_C_CHIP_ERASE = 7'h40;
  localparam logic [6:0] NVX_C_READ_NVM  = 7'h43;
  localparam logic [6:0] NVX_C_FLOAD     = 7'h23;
  localparam logic [6:0] NVX_C_FBUF_CLR  = 7'h26;
  localparam logic [6:0] NVX_C_FLASH_CRC = 7'h78;
  localparam logic [6:0] NVX_C_APP_CRC   = 7'h38;
  localparam logic [6:0] NVX_C_BOOT_ERASE = 7'h68;
  localparam logic [6:0] NVX_C_BOOT_PERA = 7'h2A;
  localparam logic [6:0] NVX_C_BOOT_PWR  = 7'h2C;
  localparam logic [6:0] NVX_C_BOOT_PEW  = 7'h2D;
  localparam logic [6:0] NVX_C_BOOT_CRC  = 7'h39;
  localparam logic [6:0] NVX_C_USIG_RD   = 7'h01;
  localparam logic [6:0] NVX_C_USIG_ER   = 7'h18;
  localparam logic [6:0] NVX_C_USIG_WR   = 7'h1A;
  localparam logic [6:0] NVX_C_CAL_RD    = 7'h02;
  localparam logic [6:0] NVX_C_FUSE_RD   = 7'h07;
  localparam logic [6:0] NVX_C_FUSE_WR   = 7'h4C;
  localparam logic [6:0] NVX_C_LOCK_WR   = 7'h08;
  localparam logic [6:0] NVX_C_ELOAD     = 7'h33;
  localparam logic [6:0] NVX_C_EBUF_CLR  = 7'h36;
  localparam logic [6:0] NVX_C_EE_ERASE  = 7'h30;
  localparam logic [6:0] NVX_C_EE_PERA   = 7'h32;
  localparam logic [6:0] NVX_C_EE_PWR    = 7'h34;
  localparam logic [6:0] NVX_C_EE_PEW    = 7'h35;
  localparam logic [6:0] NVX_C_EE_RD     = 7'h06;

  // commands started by the execute bit
  function automatic logic nvx_is_action(input logic [6:0] c);
    return c inside {NVX_C_CHIP_ERASE, NVX_C_FBUF_CLR, NVX_C_FLASH_CRC, NVX_C_BOOT_CRC,
                     NVX_C_LOCK_WR, NVX_C_EBUF_CLR, NVX_C_EE_ERASE};
  endfunction

  // commands started by a debug-port load
  function automatic logic nvx_is_read(input logic [6:0] c);
    return c inside {NVX_C_READ_NVM, NVX_C_USIG_RD, NVX_C_CAL_RD, NVX_C_FUSE_RD, NVX_C_EE_RD};
  endfunction

  // commands handed to the array back end (erase and program operations)
  function automatic logic nvx_is_backend(input logic [6:0] c);
    return c inside {NVX_C_CHIP_ERASE, NVX_C_BOOT_ERASE, NVX_C_BOOT_PERA, NVX_C_BOOT_PWR,
                     NVX_C_BOOT_PEW, NVX_C_USIG_ER, NVX_C_USIG_WR, NVX_C_EE_ERASE,
                     NVX_C_EE_PERA, NVX_C_EE_PWR, NVX_C_EE_PEW};
  endfunction

  // commands started by a debug-port store
  function automatic logic nvx_is_write(input logic [6:0] c);
    return (nvx_is_backend(c) && c != NVX_C_CHIP_ERASE && c != NVX_C_EE_ERASE) ||
           c inside {NVX_C_FLOAD, NVX_C_ELOAD, NVX_C_FUSE_WR, NVX_C_LOCK_WR};
  endfunction

endpackage

//--- tb.sv
// Purpose: self-checking bench of the nvm command sequencer
// Assumes: back end model answers reads with address xor 0x5A
// Notes:   crc ranges shrunk to four bytes to keep the run short
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import nvx_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, dp_wr = 1'b0, dp_rd = 1'b0, rd_d = 1'b0;
  logic [7:0]  reg_addr = 8'h00, dp_wdata = 8'h00, dp_rdata, mem_rd_data, delay = 8'h04, r, lo, hi;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [23:0] dp_addr = 24'h0, mem_addr, mem_rd_addr, a, s_addr;
  logic        dp_rvalid, dp_stall, mem_start, keep, mem_done, mem_rd, busy, ifen, s_keep;
  logic [6:0]  mem_cmd, s_cmd, rdc[4] = '{NVX_C_READ_NVM, NVX_C_USIG_RD, NVX_C_CAL_RD, NVX_C_EE_RD};
  logic [6:0]  pgc[9] = '{NVX_C_BOOT_PEW, NVX_C_USIG_ER, NVX_C_USIG_WR, NVX_C_EE_PERA, NVX_C_EE_PWR, NVX_C_EE_PEW,
                          NVX_C_BOOT_PERA, NVX_C_BOOT_PWR, NVX_C_BOOT_ERASE};
  logic [5:0]  buf_idx = 6'h00;
  logic [16:0] buf_data;
  logic [31:0] reg_q[$];
  logic [7:0]  dp_q[$];
  int          miscompares = 0, n_compared = 0, starts = 0, s0;
  nvx_cmd #(.FLASH_BYTES(24'h000004), .BOOT_BASE(24'h800010), .BOOT_BYTES(24'h000004)) nvx_cmd_i (
    .clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .dp_addr_i(dp_addr), .dp_wdata_i(dp_wdata), .dp_wr_i(dp_wr),
    .dp_rd_i(dp_rd), .dp_rdata_o(dp_rdata), .dp_rvalid_o(dp_rvalid), .dp_stall_o(dp_stall),
    .mem_start_o(mem_start), .mem_cmd_o(mem_cmd), .mem_addr_o(mem_addr), .mem_keep_eeprom_o(keep),
    .mem_done_i(mem_done), .mem_rd_o(mem_rd), .mem_rd_addr_o(mem_rd_addr), .mem_rd_data_i(mem_rd_data),
    .buf_rd_idx_i(buf_idx), .buf_rd_data_o(buf_data), .busy_o(busy), .memory_interface_enabled_o(ifen));
  nvx_mem_model nvx_mem_model_i (.clk_i(clk), .reset_n_i(rst_n), .mem_start_i(mem_start), .delay_i(delay),
    .mem_done_o(mem_done), .mem_rd_i(mem_rd), .mem_rd_addr_i(mem_rd_addr), .mem_rd_data_o(mem_rd_data));
  initial forever #2.5 clk = ~clk;
  // monitor: oldest note is matched against each answer as it appears
  always @(posedge clk) begin
    if (rd_d) `CHK(reg_rdata, reg_q.pop_front())
    if (dp_rvalid === 1'b1) `CHK(dp_rdata, dp_q.pop_front())
    if (mem_start === 1'b1) begin
      starts++;
      s_cmd = mem_cmd;
      s_addr = mem_addr;
      s_keep = keep;
    end
    rd_d <= reg_rd;
  end
  // register port cycle; a read notes its expected word
  task automatic reg_op(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    if (!wr) reg_q.push_back(d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  // debug-port store or load; a load notes its expected byte
  task automatic dp_op(input logic wr, input logic [23:0] ad, input logic [7:0] d);
    if (!wr) dp_q.push_back(d);
    @(posedge clk);
    dp_addr <= ad;
    dp_wdata <= d;
    dp_wr <= wr;
    dp_rd <= !wr;
    @(posedge clk);
    dp_wr <= 1'b0;
    dp_rd <= 1'b0;
  endtask
  // bounded wait until neither busy nor stalled
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #1;
    while ((busy !== 1'b0 || dp_stall !== 1'b0) && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 3000) miscompares++;
  endtask
  task automatic buf_chk(input logic [5:0] i, input logic [16:0] e);
    @(posedge clk);
    buf_idx <= i;
    repeat (2) @(posedge clk);
    #1;
    `CHK(buf_data, e)
  endtask
  function automatic logic [15:0] crc_of(input logic [23:0] base);
    logic [15:0] c;
    c = NVX_CRC_INIT;
    for (int i = 0; i < 4; i++) begin
      c = c ^ {8'(base + 24'(i)) ^ 8'h5A, 8'h00};
      for (int k = 0; k < 8; k++) c = c[15] ? ({c[14:0], 1'b0} ^ NVX_CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task automatic conclude();
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: well beyond the expected few hundred cycles
  initial begin
    #250000;
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(32'hC483));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reg_op(0, NVX_REG_CMD, 32'h0);
    reg_op(0, NVX_REG_STATUS, 32'h2);
    reg_op(0, NVX_REG_LOCK, 32'hFF);
    reg_op(0, 8'h14, 32'h0);
    foreach (rdc[i]) begin
      reg_op(1, NVX_REG_CMD, 32'(rdc[i]));
      a = 24'($urandom);
      dp_op(0, a, a[7:0] ^ 8'h5A);
      wait_idle();
    end
    // fuse bits only move toward programmed
    r = 8'($urandom);
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FUSE_WR));
    dp_op(1, 24'h2, r);
    wait_idle();
    dp_op(1, 24'h2, 8'hFF);
    wait_idle();
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FUSE_RD));
    dp_op(0, 24'h2, r);
    wait_idle();
    lo = 8'($urandom);
    hi = 8'($urandom);
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FLOAD));
    dp_op(1, 24'h800014, lo);
    dp_op(1, 24'h800015, hi);
    wait_idle();
    buf_chk(6'h0A, {1'b1, hi, lo});
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FBUF_CLR));
    reg_op(1, NVX_REG_CONTROL_REGISTER_A, 32'h1);
    wait_idle();
    buf_chk(6'h0A, {1'b1, 16'hFFFF});
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_ELOAD));
    dp_op(1, 24'h8C1005, r);
    wait_idle();
    buf_chk(6'h05, {1'b1, 8'h00, r});
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_EBUF_CLR));
    reg_op(1, NVX_REG_CONTROL_REGISTER_A, 32'h1);
    wait_idle();
    buf_chk(6'h05, {1'b0, 8'h00, 8'hFF});
    // page commands; a second store while busy must be ignored
    foreach (pgc[i]) begin
      delay <= 8'(2 + $urandom % 16);
      reg_op(1, NVX_REG_CMD, 32'(pgc[i]));
      a = 24'($urandom);
      s0 = starts;
      dp_op(1, a, 8'h00);
      dp_op(1, a ^ 24'h1, 8'h00);
      wait_idle();
      `CHK(starts, s0 + 1)
      `CHK(s_cmd, pgc[i])
      `CHK(s_addr, a)
    end
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_EE_ERASE));
    reg_op(1, NVX_REG_CONTROL_REGISTER_A, 32'h1);
    wait_idle();
    `CHK(s_cmd, NVX_C_EE_ERASE)
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_BOOT_CRC));
    reg_op(1, NVX_REG_CONTROL_REGISTER_A, 32'h1);
    #1;
    `CHK(busy, 1'b1)
    wait_idle();
    reg_op(0, NVX_REG_DATA, {16'h0, crc_of(24'h800010)});
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_LOCK_WR));
    dp_op(1, 24'h0, 8'hFE);
    wait_idle();
    reg_op(0, NVX_REG_LOCK, 32'hFE);
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FUSE_WR));
    dp_op(1, 24'h5, 8'hF7);
    wait_idle();
    delay <= 8'h14;
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_CHIP_ERASE));
    reg_op(1, NVX_REG_CONTROL_REGISTER_A, 32'h1);
    #1;
    `CHK(ifen, 1'b0)
    reg_op(0, NVX_REG_STATUS, 32'h1);
    wait_idle();
    `CHK(s_keep, 1'b1)
    `CHK(ifen, 1'b1)
    reg_op(0, NVX_REG_LOCK, 32'hFF);
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FUSE_RD));
    dp_op(0, 24'h5, 8'hF7);
    wait_idle();
    // full lock: only chip erase and flash crc may run
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_LOCK_WR));
    dp_op(1, 24'h0, 8'hFC);
    wait_idle();
    reg_op(0, NVX_REG_STATUS, 32'h6);
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FUSE_RD));
    dp_op(0, 24'h5, 8'h00);
    wait_idle();
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_EE_PWR));
    s0 = starts;
    dp_op(1, 24'h8C1000, 8'h00);
    wait_idle();
    `CHK(starts, s0)
    reg_op(1, NVX_REG_CMD, 32'(NVX_C_FLASH_CRC));
    reg_op(1, NVX_REG_CONTROL_REGISTER_A, 32'h1);
    #1;
    `CHK(ifen, 1'b0)
    wait_idle();
    reg_op(0, NVX_REG_DATA, {16'h0, crc_of(24'h800000)});
    repeat (3) @(posedge clk);
    `CHK(reg_q.size() + dp_q.size(), 0)
    conclude();
  end
endmodule
